// ===== pcseq_regs.svh
// What this block does
// - Ten-bit counter, two-bit high, eight-bit low.
// - Counter advances by one per instruction.
// - Jump or call loads full ten-bit target.
// - Nine skip instructions advance counter by two.
// - Bit test skips when bit matches polarity.
// - Compare skips when accumulator equals operand.
// - Increment skips only on wrap to zero.
// - Decrement skips only when one becomes zero.
// - Add overflow on low byte bumps high.
// - High byte never decrements on borrow.
// - Move to low byte jumps within page.
// - Two pointers address RAM: bank, location.
// - Pointers address table reads, also working registers.
// - Table read: high byte result, low accumulator.
// - Immediate RAM moves only to 0x80..0x87.
// - Bank-0 move links accumulator and RAM.
// - Four-level return stack saves the counter.
// - Push decrements pointer, pop increments it.
// - Returns restore the newest saved counter.
`ifndef PCSEQ_REGS_SVH
`define PCSEQ_REGS_SVH

// ---------------------------------------------------------------------
// Register indices; byte address is four times the index.
// ---------------------------------------------------------------------
`define IDX_TABLE_HIGH 8'h82
`define IDX_POINTER_LOW 8'h83
`define IDX_POINTER_BANK 8'h84
`define IDX_COUNTER_LOW 8'hCE
`define IDX_COUNTER_HIGH 8'hCF
`define IDX_STACK_LEVEL 8'hDF

// ---------------------------------------------------------------------
// Reset values and arithmetic constants.
// ---------------------------------------------------------------------
`define PC_RESET 10'h000
`define PTR_RESET 8'h00
`define STACK_LEVEL_RESET_BIT 1'b1
`define PC_STEP 10'h001
`define PC_SKIP_STEP 10'h002
`define INC_SKIP_FROM 8'hFF
`define DEC_SKIP_FROM 8'h01
`define IMM_RAM_FIRST 8'h80
`define IMM_RAM_LAST 8'h87

`endif

// ===== pcseq_pkg.sv
`default_nettype none

package pcseq_pkg;

  // Instruction classes that the sequencer acts upon.
  typedef enum logic [4:0] {
    OP_NEXT = 5'h00,
    OP_JUMP = 5'h01,
    OP_CALL = 5'h02,
    OP_INT_ENTRY = 5'h03,
    OP_RETURN = 5'h04,
    OP_INTERRUPT_RETURN = 5'h05,
    OP_COMPARE_SKIP = 5'h06,
    OP_INCREMENT_SKIP = 5'h07,
    OP_INCREMENT_MEMORY_SKIP = 5'h08,
    OP_DECREMENT_SKIP = 5'h09,
    OP_DECREMENT_MEMORY_SKIP = 5'h0A,
    OP_BIT_CLEAR_SKIP = 5'h0B,
    OP_BIT_SET_SKIP = 5'h0C,
    OP_BANK0_BIT_CLEAR_SKIP = 5'h0D,
    OP_BANK0_BIT_SET_SKIP = 5'h0E,
    OP_ADD_LOW = 5'h0F,
    OP_SUB_LOW = 5'h10,
    OP_MOVE_LOW = 5'h11,
    OP_TABLE_READ = 5'h12,
    OP_MOVE_IMMEDIATE = 5'h13,
    OP_BANK0_MOVE_TO_RAM = 5'h14,
    OP_BANK0_MOVE_TO_ACC = 5'h15
  } op_t;

endpackage

`default_nettype wire

// ===== pc_sequencer_and_pointers.sv
`include "pcseq_regs.svh"
`default_nettype none

module pc_sequencer_and_pointers #(
  parameter int STACK_LEVELS = 4
) (
  // Clock and reset.
  input wire logic I_CLK,
  input wire logic I_NRST,
  // APB slave.
  input wire logic [11:0] I_PADDR,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Instruction execution from the core.
  input wire logic I_EXEC,
  input wire pcseq_pkg::op_t I_OP,
  input wire logic [7:0] I_ACC,
  input wire logic [7:0] I_DATA,
  input wire logic I_CARRY,
  input wire logic [2:0] I_BIT,
  input wire logic [7:0] I_ADDR,
  input wire logic [9:0] I_TARGET,
  // Program memory word for table reads.
  input wire logic [15:0] I_ROM_WORD,
  // Sequencer state.
  output logic [9:0] O_PC,
  output logic O_BUSY,
  output logic [$clog2(STACK_LEVELS)-1:0] O_STACK_LEVEL,
  // Writes back to the accumulator and data memory.
  output logic O_ACC_WR,
  output logic [7:0] O_ACC_DATA,
  output logic O_RAM_WR,
  output logic [7:0] O_RAM_ADDR,
  output logic [7:0] O_RAM_DATA,
  output logic O_IMM_REFUSED,
  // Pointer addresses.
  output logic [15:0] O_IND_ADDR,
  output logic [15:0] O_ROM_ADDR
);

  localparam int SPW = $clog2(STACK_LEVELS);

  // Only power-of-two depths of at least two wrap the pointer correctly.
  generate
    if (STACK_LEVELS < 2 || (1 << SPW) != STACK_LEVELS) begin : g_bad_depth
      $error("STACK_LEVELS must be a power of two of at least two.");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  logic [9:0] pc;
  logic [7:0] table_high_result;
  logic [7:0] pointer_low;
  logic [7:0] pointer_bank;
  logic [SPW-1:0] stack_level_pointer;
  logic [9:0] stack_mem [STACK_LEVELS];
  logic busy;

  // Accepted instruction, skip decision and the counter's next value.
  logic go;
  logic skip;
  logic push;
  logic pop;
  logic [8:0] low_sum;
  logic [9:0] next_pc;
  logic [9:0] push_value;
  logic [SPW-1:0] push_idx;
  logic [SPW-1:0] pop_idx;
  logic imm_ok;
  logic core_ram_wr;

  // APB decode.
  logic apb_access;
  logic apb_wr;
  logic [7:0] reg_idx;
  logic mapped;
  logic [7:0] read_value;

  assign go = I_EXEC & ~busy;
  assign push = go & (I_OP == pcseq_pkg::OP_CALL || I_OP == pcseq_pkg::OP_INT_ENTRY);
  assign pop = go & (I_OP == pcseq_pkg::OP_RETURN ||
                     I_OP == pcseq_pkg::OP_INTERRUPT_RETURN);
  // The newest entry sits one above the pointer; a push fills the slot below.
  assign push_idx = ~stack_level_pointer;
  assign pop_idx = ~SPW'(stack_level_pointer + 1'b1);
  assign imm_ok = (I_ADDR >= `IMM_RAM_FIRST) && (I_ADDR <= `IMM_RAM_LAST);
  assign core_ram_wr = go & ((I_OP == pcseq_pkg::OP_MOVE_IMMEDIATE && imm_ok) ||
                             I_OP == pcseq_pkg::OP_BANK0_MOVE_TO_RAM);

  // Data written to RAM: the immediate for immediate moves, else the accumulator.
  function automatic logic [7:0] ram_write_value();
    return (I_OP == pcseq_pkg::OP_MOVE_IMMEDIATE) ? I_DATA : I_ACC;
  endfunction

  // ---------------------------------------------------------------------
  // Skip decision and next counter value.
  // ---------------------------------------------------------------------

  // Decides whether the instruction after the current one is skipped.
  always_comb begin
    unique case (I_OP)
      pcseq_pkg::OP_COMPARE_SKIP: begin
        skip = (I_ACC == I_DATA);
      end
      pcseq_pkg::OP_INCREMENT_SKIP, pcseq_pkg::OP_INCREMENT_MEMORY_SKIP: begin
        skip = (I_DATA == `INC_SKIP_FROM);
      end
      pcseq_pkg::OP_DECREMENT_SKIP, pcseq_pkg::OP_DECREMENT_MEMORY_SKIP: begin
        skip = (I_DATA == `DEC_SKIP_FROM);
      end
      pcseq_pkg::OP_BIT_CLEAR_SKIP, pcseq_pkg::OP_BANK0_BIT_CLEAR_SKIP: begin
        skip = ~I_DATA[I_BIT];
      end
      pcseq_pkg::OP_BIT_SET_SKIP, pcseq_pkg::OP_BANK0_BIT_SET_SKIP: begin
        skip = I_DATA[I_BIT];
      end
      default: begin
        skip = 1'b0;
      end
    endcase
  end

  // Low byte plus accumulator, with the carry out feeding the high byte.
  assign low_sum = {1'b0, pc[7:0]} + {1'b0, I_ACC} + {8'h00, I_CARRY};

  // Picks the address of the next instruction.
  always_comb begin
    push_value = (I_OP == pcseq_pkg::OP_CALL) ? 10'(pc + `PC_STEP) : pc;
    unique case (I_OP)
      pcseq_pkg::OP_JUMP, pcseq_pkg::OP_CALL, pcseq_pkg::OP_INT_ENTRY: begin
        next_pc = I_TARGET;
      end
      pcseq_pkg::OP_RETURN, pcseq_pkg::OP_INTERRUPT_RETURN: begin
        next_pc = stack_mem[pop_idx];
      end
      pcseq_pkg::OP_ADD_LOW: begin
        next_pc = {2'(pc[9:8] + {1'b0, low_sum[8]}), low_sum[7:0]};
      end
      pcseq_pkg::OP_SUB_LOW: begin
        next_pc = {pc[9:8], 8'(pc[7:0] - I_ACC)};
      end
      pcseq_pkg::OP_MOVE_LOW: begin
        next_pc = {pc[9:8], I_ACC};
      end
      default: begin
        next_pc = skip ? 10'(pc + `PC_SKIP_STEP) : 10'(pc + `PC_STEP);
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // APB slave: one wait state, then a one-cycle answer.
  // ---------------------------------------------------------------------
  assign apb_access = I_PSEL & I_PENABLE;
  assign apb_wr = apb_access & O_PREADY & I_PWRITE & I_PSTRB[0];
  assign reg_idx = I_PADDR[9:2];

  // Looks up the addressed register; unmapped words read zero.
  always_comb begin
    mapped = (I_PADDR[11:10] == 2'h0) && (I_PADDR[1:0] == 2'h0);
    read_value = 8'h00;
    unique case (reg_idx)
      `IDX_TABLE_HIGH: read_value = table_high_result;
      `IDX_POINTER_LOW: read_value = pointer_low;
      `IDX_POINTER_BANK: read_value = pointer_bank;
      `IDX_COUNTER_LOW: read_value = pc[7:0];
      `IDX_COUNTER_HIGH: read_value = {6'h00, pc[9:8]};
      `IDX_STACK_LEVEL: read_value = 8'(stack_level_pointer);
      default: mapped = 1'b0;
    endcase
  end

  // Raises ready for one cycle after each setup and registers the answer.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PREADY <= 1'b0;
      O_PRDATA <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY <= apb_access & ~O_PREADY;
      O_PRDATA <= (apb_access & ~O_PREADY & ~I_PWRITE & mapped) ?
                  {24'h00_0000, read_value} : 32'h0000_0000;
      O_PSLVERR <= apb_access & ~O_PREADY & ~mapped;
    end
  end

  // ---------------------------------------------------------------------
  // Program counter and stack.
  // ---------------------------------------------------------------------

  // Executes one instruction per accepted request; the core beats software.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pc <= `PC_RESET;
    end else if (go) begin
      pc <= next_pc;
    end else if (apb_wr && mapped && reg_idx == `IDX_COUNTER_LOW) begin
      pc <= {pc[9:8], I_PWDATA[7:0]};
    end else if (apb_wr && mapped && reg_idx == `IDX_COUNTER_HIGH) begin
      pc <= {I_PWDATA[1:0], pc[7:0]};
    end
  end

  // Moves the stack pointer down on a push and up on a pop.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      stack_level_pointer <= {SPW{`STACK_LEVEL_RESET_BIT}};
    end else if (push) begin
      stack_level_pointer <= SPW'(stack_level_pointer - 1'b1);
    end else if (pop) begin
      stack_level_pointer <= SPW'(stack_level_pointer + 1'b1);
    end else if (apb_wr && mapped && reg_idx == `IDX_STACK_LEVEL) begin
      stack_level_pointer <= I_PWDATA[SPW-1:0];
    end
  end

  // Each stack entry saves the counter when a push selects it.
  generate
    for (genvar e = 0; e < STACK_LEVELS; e++) begin : g_stack
      always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          stack_mem[e] <= `PC_RESET;
        end else if (push && push_idx == SPW'(e)) begin
          stack_mem[e] <= push_value;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Pointer and result registers.
  // ---------------------------------------------------------------------

  // Location pointer: core moves win over software writes.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pointer_low <= `PTR_RESET;
    end else if (core_ram_wr && I_ADDR == `IDX_POINTER_LOW) begin
      pointer_low <= ram_write_value();
    end else if (apb_wr && mapped && reg_idx == `IDX_POINTER_LOW) begin
      pointer_low <= I_PWDATA[7:0];
    end
  end

  // Bank pointer: core moves win over software writes.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      pointer_bank <= `PTR_RESET;
    end else if (core_ram_wr && I_ADDR == `IDX_POINTER_BANK) begin
      pointer_bank <= ram_write_value();
    end else if (apb_wr && mapped && reg_idx == `IDX_POINTER_BANK) begin
      pointer_bank <= I_PWDATA[7:0];
    end
  end

  // Result register takes the high table byte, a core move or software.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      table_high_result <= `PTR_RESET;
    end else if (busy) begin
      table_high_result <= I_ROM_WORD[15:8];
    end else if (core_ram_wr && I_ADDR == `IDX_TABLE_HIGH) begin
      table_high_result <= ram_write_value();
    end else if (apb_wr && mapped && reg_idx == `IDX_TABLE_HIGH) begin
      table_high_result <= I_PWDATA[7:0];
    end
  end

  // Bank and location pointers drive the indirect RAM port.
  assign O_IND_ADDR = {pointer_bank, pointer_low};

  // ---------------------------------------------------------------------
  // Table read and write-back outputs.
  // ---------------------------------------------------------------------

  // Holds the table address for the one cycle the program memory answers.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      busy <= 1'b0;
      O_ROM_ADDR <= 16'h0000;
    end else if (go && I_OP == pcseq_pkg::OP_TABLE_READ) begin
      busy <= 1'b1;
      O_ROM_ADDR <= {pointer_bank, pointer_low};
    end else begin
      busy <= 1'b0;
    end
  end

  // Accumulator write-back for table reads, counting skips and bank-0 loads.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_ACC_WR <= 1'b0;
      O_ACC_DATA <= 8'h00;
    end else if (busy) begin
      O_ACC_WR <= 1'b1;
      O_ACC_DATA <= I_ROM_WORD[7:0];
    end else if (go && I_OP == pcseq_pkg::OP_INCREMENT_SKIP) begin
      O_ACC_WR <= 1'b1;
      O_ACC_DATA <= 8'(I_DATA + 8'h01);
    end else if (go && I_OP == pcseq_pkg::OP_DECREMENT_SKIP) begin
      O_ACC_WR <= 1'b1;
      O_ACC_DATA <= 8'(I_DATA - 8'h01);
    end else if (go && I_OP == pcseq_pkg::OP_BANK0_MOVE_TO_ACC) begin
      O_ACC_WR <= 1'b1;
      O_ACC_DATA <= I_DATA;
    end else begin
      O_ACC_WR <= 1'b0;
    end
  end

  // Memory write-back for counting skips and moves; bad immediates are refused.
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RAM_WR <= 1'b0;
      O_RAM_ADDR <= 8'h00;
      O_RAM_DATA <= 8'h00;
      O_IMM_REFUSED <= 1'b0;
    end else begin
      O_RAM_WR <= 1'b0;
      O_IMM_REFUSED <= go & (I_OP == pcseq_pkg::OP_MOVE_IMMEDIATE) & ~imm_ok;
      if (go && I_OP == pcseq_pkg::OP_INCREMENT_MEMORY_SKIP) begin
        O_RAM_WR <= 1'b1;
        O_RAM_ADDR <= I_ADDR;
        O_RAM_DATA <= 8'(I_DATA + 8'h01);
      end else if (go && I_OP == pcseq_pkg::OP_DECREMENT_MEMORY_SKIP) begin
        O_RAM_WR <= 1'b1;
        O_RAM_ADDR <= I_ADDR;
        O_RAM_DATA <= 8'(I_DATA - 8'h01);
      end else if (core_ram_wr) begin
        O_RAM_WR <= 1'b1;
        O_RAM_ADDR <= I_ADDR;
        O_RAM_DATA <= ram_write_value();
      end
    end
  end

  assign O_PC = pc;
  assign O_BUSY = busy;
  assign O_STACK_LEVEL = stack_level_pointer;

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);

  a_pc_step_one: assert property (
    go && I_OP == pcseq_pkg::OP_NEXT |=> O_PC == 10'($past(O_PC) + 10'h001))
    else $error("Counter did not advance by one.");

  a_jump_load_target: assert property (
    go && I_OP == pcseq_pkg::OP_JUMP |=> O_PC == $past(I_TARGET))
    else $error("Jump target not loaded.");

  a_compare_skip_two: assert property (
    go && I_OP == pcseq_pkg::OP_COMPARE_SKIP && I_ACC == I_DATA
    |=> O_PC == 10'($past(O_PC) + 10'h002))
    else $error("Equal compare did not skip.");

  a_increment_skip_wrap: assert property (
    go && I_OP == pcseq_pkg::OP_INCREMENT_SKIP && I_DATA != 8'hFF
    |=> O_PC == 10'($past(O_PC) + 10'h001) && O_ACC_WR && O_ACC_DATA != 8'h00)
    else $error("Increment skipped without wrapping.");

  a_decrement_skip_zero: assert property (
    go && I_OP == pcseq_pkg::OP_DECREMENT_MEMORY_SKIP && I_DATA == 8'h01
    |=> O_PC == 10'($past(O_PC) + 10'h002) && O_RAM_WR && O_RAM_DATA == 8'h00)
    else $error("Decrement to zero did not skip.");

  a_bit_set_skip: assert property (
    go && I_OP == pcseq_pkg::OP_BIT_SET_SKIP && !I_DATA[I_BIT]
    |=> O_PC == 10'($past(O_PC) + 10'h001))
    else $error("Clear bit skipped a set-bit test.");

  a_add_carry_high: assert property (
    go && I_OP == pcseq_pkg::OP_ADD_LOW && low_sum[8]
    |=> O_PC[9:8] == 2'($past(O_PC[9:8]) + 2'h1))
    else $error("Low-byte carry lost.");

  a_sub_keep_high: assert property (
    go && I_OP == pcseq_pkg::OP_SUB_LOW |=> $stable(O_PC[9:8]))
    else $error("High byte changed on subtract.");

  a_call_push_level: assert property (
    go && I_OP == pcseq_pkg::OP_CALL
    |=> O_STACK_LEVEL == SPW'($past(O_STACK_LEVEL) - 1'b1))
    else $error("Call did not lower the stack pointer.");

  a_call_return_pair: assert property (
    go && I_OP == pcseq_pkg::OP_CALL ##1 !go ##1 go && I_OP == pcseq_pkg::OP_RETURN
    |=> O_PC == 10'($past(O_PC, 3) + 10'h001))
    else $error("Return did not restore the call site.");

  a_imm_range_refused: assert property (
    go && I_OP == pcseq_pkg::OP_MOVE_IMMEDIATE && !imm_ok |=> O_IMM_REFUSED && !O_RAM_WR)
    else $error("Out-of-range immediate move accepted.");

  a_table_read_split: assert property (
    go && I_OP == pcseq_pkg::OP_TABLE_READ ##1 1'b1
    |=> O_ACC_WR && O_ACC_DATA == $past(I_ROM_WORD[7:0]))
    else $error("Table low byte not returned.");

endmodule

`default_nettype wire

// ===== core_memory_model.sv
`default_nettype none

// ---------------------------------------------------------------------
// Program and data memory standing beside the sequencer.
// ---------------------------------------------------------------------
module core_memory_model (
  // Clock.
  input wire logic clk,
  // Program memory side.
  input wire logic [15:0] rom_addr,
  input wire logic rom_busy,
  output logic [15:0] rom_word,
  // Data memory side.
  input wire logic ram_wr,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] ram [256];

  // The word is a fixed scramble of its address; outside a fetch the bus shows its inverse.
  always_comb begin
    rom_word = rom_addr ^ 16'h5AC3;
    if (!rom_busy) begin
      rom_word = ~rom_word;
    end
  end

  // Data memory takes each write pulse at the clock edge.
  always_ff @(posedge clk) begin
    if (ram_wr) begin
      ram[ram_addr] <= ram_data;
    end
  end
endmodule

`default_nettype wire

// ===== test_pc_sequencer_and_pointers.sv
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fails++; $display("Error at %0t: got %0h, expected %0h", $time, g, e); end end

module test_pc_sequencer_and_pointers;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, nrst, psel, penable, pwrite, pready, pslverr, exec, carry;
  logic busy, acc_wr, ram_wr, imm_ref;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  pcseq_pkg::op_t op;
  logic [7:0] acc, data, addr, acc_data, ram_addr, ram_data;
  logic [2:0] bitn;
  logic [9:0] target, pc, epc;
  logic [15:0] rom_word, ind_addr, rom_addr, w;
  logic [1:0] lvl, elvl;
  logic [9:0] stk[$];
  logic er;
  int fails = 0;
  int n_tests = 0;

  pc_sequencer_and_pointers i_pc_sequencer_and_pointers (
    .I_CLK(clk), .I_NRST(nrst), .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_EXEC(exec), .I_OP(op), .I_ACC(acc),
    .I_DATA(data), .I_CARRY(carry), .I_BIT(bitn), .I_ADDR(addr), .I_TARGET(target),
    .I_ROM_WORD(rom_word), .O_PC(pc), .O_BUSY(busy), .O_STACK_LEVEL(lvl),
    .O_ACC_WR(acc_wr), .O_ACC_DATA(acc_data), .O_RAM_WR(ram_wr), .O_RAM_ADDR(ram_addr),
    .O_RAM_DATA(ram_data), .O_IMM_REFUSED(imm_ref), .O_IND_ADDR(ind_addr),
    .O_ROM_ADDR(rom_addr));

  core_memory_model i_core_memory_model (
    .clk(clk), .rom_addr(rom_addr), .rom_busy(busy), .rom_word(rom_word),
    .ram_wr(ram_wr), .ram_addr(ram_addr), .ram_data(ram_data));

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // Expectations, bus cycles and the verdict.
  // ---------------------------------------------------------------------
  function automatic logic skip_exp(input pcseq_pkg::op_t o, input logic [7:0] a,
                                    input logic [7:0] d, input logic [2:0] b);
    case (o)
      pcseq_pkg::OP_COMPARE_SKIP: return a == d;
      pcseq_pkg::OP_INCREMENT_SKIP, pcseq_pkg::OP_INCREMENT_MEMORY_SKIP: return d == 8'hFF;
      pcseq_pkg::OP_DECREMENT_SKIP, pcseq_pkg::OP_DECREMENT_MEMORY_SKIP: return d == 8'h01;
      pcseq_pkg::OP_BIT_CLEAR_SKIP, pcseq_pkg::OP_BANK0_BIT_CLEAR_SKIP: return !d[b];
      default: return d[b];
    endcase
  endfunction

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request is held until pready is seen high.
  // The task returns 1 ns after that edge, so a write has landed when it is checked.
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      $display("Error at %0t: no ready", $time);
      conclude();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // One instruction, taken at the edge after it is presented; outputs settle 1 ns later.
  task automatic ex(input pcseq_pkg::op_t o, input logic [7:0] a, input logic [7:0] d,
                    input logic [2:0] b, input logic [7:0] ad, input logic [9:0] t,
                    input logic c);
    @(posedge clk);
    exec <= 1'b1;
    op <= o;
    acc <= a;
    data <= d;
    bitn <= b;
    addr <= ad;
    target <= t;
    carry <= c;
    @(posedge clk);
    exec <= 1'b0;
    #1;
  endtask

  // Main sequence.
  initial begin
    int i, k;
    logic [7:0] a, d, ad, y, z, r;
    logic [9:0] t;
    logic c, inr;
    pcseq_pkg::op_t o;
    {nrst, psel, penable, pwrite, exec, carry, paddr, pwdata, acc, data, addr} = '0;
    {bitn, target} = '0;
    pstrb = 4'hF;
    op = pcseq_pkg::OP_NEXT;
    void'($urandom(32'h8CA1));
    repeat (10) @(posedge clk);
    `CHK(pc, 10'h000)
    `CHK(lvl, 2'h3)
    nrst <= 1'b1;
    elvl = 2'h3;
    for (i = 0; i < 4; i++) begin
      t = (i == 0) ? 10'h3FF : 10'($urandom);
      epc = t;
      ex(pcseq_pkg::OP_JUMP, 8'h00, 8'h00, 3'h0, 8'h00, t, 1'b0);
      `CHK(pc, epc)
      epc = epc + 10'h001;
      ex(pcseq_pkg::OP_NEXT, 8'h00, 8'h00, 3'h0, 8'h00, 10'h000, 1'b0);
      `CHK(pc, epc)
    end
    a = 8'($urandom);
    apb(1'b1, 8'hCF, 8'h02);
    apb(1'b1, 8'hCE, a);
    epc = {2'h2, a};
    `CHK(pc, epc)
    apb(1'b0, 8'hCF, 8'h00);
    `CHK(rd, 32'h00000002)
    apb(1'b0, 8'hCE, 8'h00);
    `CHK(rd, {24'h000000, a})
    for (k = 0; k < 9; k++) begin
      for (i = 0; i < 6; i++) begin
        o = pcseq_pkg::op_t'(5'h06 + 5'(k));
        a = 8'($urandom);
        d = 8'($urandom);
        if (i[0]) begin
          d = (k == 0) ? a : (k <= 2) ? 8'hFF : (k <= 4) ? 8'h01 : d;
        end
        c = skip_exp(o, a, d, 3'(i));
        epc = epc + (c ? 10'h002 : 10'h001);
        ex(o, a, d, 3'(i), 8'h40, 10'h000, 1'b0);
        `CHK(pc, epc)
        if (k >= 1 && k <= 4) begin
          r = (k <= 2) ? d + 8'h01 : d - 8'h01;
          `CHK(k[0] ? acc_wr : ram_wr, 1'b1)
          `CHK(k[0] ? acc_data : ram_data, r)
        end
      end
    end
    for (i = 0; i < 18; i++) begin
      t = (i < 3) ? {2'h1, 8'hF0} : 10'($urandom);
      a = (i < 3) ? 8'h20 : 8'($urandom);
      c = 1'($urandom);
      ex(pcseq_pkg::OP_JUMP, 8'h00, 8'h00, 3'h0, 8'h00, t, 1'b0);
      o = pcseq_pkg::op_t'(5'h0F + 5'(i % 3));
      r = t[7:0] + a + {7'h00, c};
      epc = (i % 3 == 0) ? {t[9:8] + 2'(t[7:0] + {1'b0, a} + c > 9'h0FF), r} :
            (i % 3 == 1) ? {t[9:8], t[7:0] - a} : {t[9:8], a};
      ex(o, a, 8'h00, 3'h0, 8'h00, 10'h000, c);
      `CHK(pc, epc)
    end
    for (i = 0; i < 2; i++) begin
      y = 8'($urandom);
      z = 8'($urandom);
      apb(1'b1, 8'h83, z);
      apb(1'b1, 8'h84, y);
      apb(1'b0, 8'h83, 8'h00);
      `CHK(rd, {24'h000000, z})
      `CHK(ind_addr, {y, z})
      epc = epc + 10'h001;
      ex(pcseq_pkg::OP_TABLE_READ, 8'h00, 8'h00, 3'h0, 8'h00, 10'h000, 1'b0);
      `CHK(busy, 1'b1)
      `CHK(rom_addr, {y, z})
      w = {y, z} ^ 16'h5AC3;
      @(posedge clk);
      #1;
      `CHK(acc_data, w[7:0])
      apb(1'b0, 8'h82, 8'h00);
      `CHK(rd, {24'h000000, w[15:8]})
      `CHK(pc, epc)
    end
    apb(1'b0, 8'h85, 8'h00);
    `CHK({er, rd}, 33'h100000000)
    for (ad = 8'h7E; ad < 8'h8A; ad++) begin
      d = 8'($urandom);
      inr = ad >= 8'h80 && ad <= 8'h87;
      ex(pcseq_pkg::OP_MOVE_IMMEDIATE, 8'h00, d, 3'h0, ad, 10'h000, 1'b0);
      `CHK({ram_wr, imm_ref}, {inr, !inr})
    end
    for (i = 0; i < 4; i++) begin
      a = 8'($urandom);
      ad = {1'b0, 7'($urandom)};
      ex(pcseq_pkg::OP_BANK0_MOVE_TO_RAM, a, 8'h00, 3'h0, ad, 10'h000, 1'b0);
      @(posedge clk);
      #1;
      `CHK(i_core_memory_model.ram[ad], a)
      ex(pcseq_pkg::OP_BANK0_MOVE_TO_ACC, 8'h00, ~a, 3'h0, ad, 10'h000, 1'b0);
      `CHK({acc_wr, acc_data}, {1'b1, ~a})
    end
    epc = pc;
    for (i = 0; i < 4; i++) begin
      t = 10'($urandom);
      o = (i == 2) ? pcseq_pkg::OP_INT_ENTRY : pcseq_pkg::OP_CALL;
      stk.push_back((i == 2) ? epc : epc + 10'h001);
      epc = t;
      elvl = elvl - 2'h1;
      ex(o, 8'h00, 8'h00, 3'h0, 8'h00, t, 1'b0);
      `CHK({lvl, pc}, {elvl, epc})
    end
    for (i = 0; i < 4; i++) begin
      o = i[0] ? pcseq_pkg::OP_INTERRUPT_RETURN : pcseq_pkg::OP_RETURN;
      epc = stk.pop_back();
      elvl = elvl + 2'h1;
      ex(o, 8'h00, 8'h00, 3'h0, 8'h00, 10'h000, 1'b0);
      `CHK({lvl, pc}, {elvl, epc})
    end
    apb(1'b0, 8'hDF, 8'h00);
    `CHK(rd, {30'h00000000, elvl})
    conclude();
  end
endmodule

`default_nettype wire
